// *** verilog/csfm_pkg.sv ***
// Package: constants, types and carriers of the charger status and fault monitor
package csfm_pkg;
    // Register offsets
    localparam logic [7:0] CTL1_OFS = 8'hA8;
    localparam logic [7:0] CTL2_OFS = 8'hA9;
    localparam logic [7:0] FLAG_OFS = 8'hAA;
    localparam logic [7:0] MASK_OFS = 8'hAB;
    localparam logic [7:0] MODE_OFS = 8'hAC;
    // Field positions
    localparam int STS_LSB = 12;
    localparam int TIME_LSB = 8;
    localparam int NTC_EN_BIT = 3;
    localparam int HOT_EN_BIT = 2;
    localparam int COLD_EN_BIT = 1;
    localparam int FAST_REQ_BIT = 0;
    localparam int WARN_PAUSE_BIT = 1;
    localparam int HOT_FLAG_BIT = 15;
    localparam int COLD_FLAG_BIT = 14;
    localparam int FAIL_FLAG_BIT = 13;
    localparam int SHUT_FLAG_BIT = 5;
    localparam int WARN_FLAG_BIT = 4;
    // Values after reset
    localparam logic [3:0] TIME_RST = 4'hB;
    localparam logic EN_RST = 1'b1;
    localparam logic FAST_REQ_RST = 1'b0;
    localparam logic WARN_PAUSE_RST = 1'b1;
    localparam logic [15:0] MASK_RST = 16'h0000;
    // Status codes
    localparam logic [1:0] STS_OFF = 2'h0;
    localparam logic [1:0] STS_TRICKLE = 2'h1;
    localparam logic [1:0] STS_FAST = 2'h2;
    // Timing: clock, half-second prescale, charge-time check
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_SEC_NS = 500_000_000;
    localparam int HALF_SEC_CYC = HALF_SEC_NS / CLK_PERIOD_NS;
    localparam int HALF_PER_MIN = 120;
    localparam int CHECK_MIN = 30;
    localparam int TIMEOUT_BASE_MIN = 60;
    localparam int TIMEOUT_STEP_MIN = 30;
    localparam logic [15:0] CHECK_HALF = 16'(CHECK_MIN * HALF_PER_MIN);
    localparam logic [15:0] QTR_BASE_HALF = 16'(TIMEOUT_BASE_MIN * HALF_PER_MIN / 4);
    localparam logic [15:0] QTR_STEP_HALF = 16'(TIMEOUT_STEP_MIN * HALF_PER_MIN / 4);
    localparam logic SLOW_DIV_RST = 1'b0;

    typedef enum logic [2:0] {
        CH_OFF, CH_TRICKLE, CH_FAST, CH_SUSPEND, CH_FAIL, CH_SHUTDOWN
    } csfm_chg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } csfm_bus_t;

    typedef struct packed {
        logic cold;
        logic hot;
        logic ntc_missing;
        logic die_warn;
        logic die_shut;
        logic batt_low;
        logic start_ok;
        logic power_reapply;
        logic usb_suspend;
    } csfm_sense_t;

    typedef struct packed {
        logic prev;
        logic flag;
    } csfm_flag_t;

    typedef struct packed {
        csfm_chg_t chg;
        logic [15:0] timer;
        logic checked;
        logic [31:0] pre;
        logic slow_div;
        logic blink;
        logic [3:0] time_code;
        logic ntc_en;
        logic hot_en;
        logic cold_en;
        logic fast_req;
        logic warn_pause_en;
        logic [15:0] mask;
        logic [15:0] rdata;
        logic irq;
        logic ind_oe;
        logic ind_o;
        logic charge_en;
        logic charge_fast;
        logic [1:0] sts;
    } csfm_state_t;
endpackage

// *** verilog/csfm_event_flag.sv ***
// Rising-edge event flag, cleared by a read
`timescale 1ns/1ps
module csfm_event_flag
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Condition and read clear
    input wire logic cond,
    input wire logic clr,
    // Flag
    output logic flag_ff
);
    import csfm_pkg::*;

    csfm_flag_t q_ff;
    csfm_flag_t nxt_q;

    // Edge set beats a same-cycle read clear
    always_comb
    begin
        nxt_q.prev = cond;
        nxt_q.flag = (cond & ~q_ff.prev) | (q_ff.flag & ~clr);
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    assign flag_ff = q_ff.flag;

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        (cond && !q_ff.prev) |=> flag_ff)
        else $error("event edge lost");
endmodule

// *** verilog/csfm_monitor.sv ***
// Charger status reporting, indicator blink and battery fault handling
//
// Function
// - Charge state readable at bits 13:12: 00 off, 01 trickle, 10 fast.
// - Indicator off at zero current, 0.5 Hz blink trickle, 1 Hz blink fast.
// - Indicator is open drain: only pulls low, never drives high.
// - Battery below cold limit sets the cold event flag.
// - Battery above hot limit sets the hot event flag.
// - Charging suspended while hot or cold condition is present.
// - Trickle charging resumes automatically once temperature is normal again.
// - Bit 3, reset 1, enables acting on missing thermistor detection.
// - Bit 2, reset 1, enables the battery hot check.
// - Bit 1, reset 1, enables the battery cold check.
// - Enable bits writable only with key unlocked; read-only in ROM setups.
// - Die warning sets its flag and may pause; pausing configurable in trickle.
// - After a warning pause, charging resumes once die cools below warning.
// - Die shutdown level sets its flag, shuts down, ends charging.
// - Trickle voltage check after max of 30 minutes or quarter timeout.
// - Check below defective threshold stops charging and sets fail flag.
// - Failure clears when battery voltage rises above the threshold.
// - Failure also clears on power reapply or USB suspend.
// - On failure clear, return to initial state; restart only if allowed.
// - Fast charging with low battery falls back to trickle immediately.
// - Event flags set on rising edge, cleared when software reads them.
// - Each flag has a mask bit; masked flags do not raise the interrupt.
// - Timeout code 0 means 60 min, plus 30 min per step.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module csfm_monitor
#(
    parameter int HALF_SEC = csfm_pkg::HALF_SEC_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire csfm_pkg::csfm_bus_t bus,
    output logic [15:0] rdata_ff,
    // Security and configuration straps
    input wire logic key_unlocked,
    input wire logic rom_cfg,
    // Analogue comparators and power events
    input wire csfm_pkg::csfm_sense_t sense,
    // Charger control towards the analogue side
    output logic charge_en_ff,
    output logic charge_fast_ff,
    output logic irq_ff,
    // Open-drain indicator pin
    output logic ind_o_ff,
    output logic ind_oe_ff
);
    import csfm_pkg::*;

    csfm_state_t q_ff;
    csfm_state_t nxt_q;
    logic [4:0] flags;
    logic [4:0] conds;
    logic flag_clr;
    logic tick;
    logic temp_fault;
    logic paused;
    logic charging;
    logic [15:0] qtr;
    logic [15:0] check_at;
    logic [15:0] flag_word;

    // Qualified fault conditions
    assign conds[0] = sense.cold & q_ff.cold_en;
    assign conds[1] = sense.hot & q_ff.hot_en;
    assign conds[2] = (q_ff.chg == CH_FAIL);
    assign conds[3] = sense.die_warn;
    assign conds[4] = sense.die_shut;
    assign temp_fault = conds[0] | conds[1] | (sense.ntc_missing & q_ff.ntc_en);
    assign flag_clr = bus.rd && (bus.addr == FLAG_OFS);

    // One flag per event
    for (genvar i = 0; i < 5; i++)
    begin : g_flag
        csfm_event_flag u_flag
        (
            .clk(clk),
            .rst(rst),
            .cond(conds[i]),
            .clr(flag_clr),
            .flag_ff(flags[i])
        );
    end

    // Flags laid out as the readable word
    always_comb
    begin
        flag_word = 16'h0000;
        flag_word[COLD_FLAG_BIT] = flags[0];
        flag_word[HOT_FLAG_BIT] = flags[1];
        flag_word[FAIL_FLAG_BIT] = flags[2];
        flag_word[WARN_FLAG_BIT] = flags[3];
        flag_word[SHUT_FLAG_BIT] = flags[4];
    end

    // Time base and check point
    assign tick = (q_ff.pre == 32'(HALF_SEC - 1));
    assign charging = (q_ff.chg == CH_TRICKLE) || (q_ff.chg == CH_FAST);
    assign paused = sense.die_warn && ((q_ff.chg == CH_FAST) || q_ff.warn_pause_en);
    assign qtr = QTR_BASE_HALF + 16'({12'h000, q_ff.time_code} * QTR_STEP_HALF);
    assign check_at = (qtr > CHECK_HALF) ? qtr : CHECK_HALF;

    // Next state
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.rdata = 16'h0000;
        nxt_q.ind_o = 1'b0;
        nxt_q.pre = tick ? 32'h0000_0000 : q_ff.pre + 32'h0000_0001;
        // Charge timer halts while paused
        if (charging && !paused && tick && (q_ff.timer != 16'hFFFF))
        begin
            nxt_q.timer = q_ff.timer + 16'h0001;
        end
        // Charger state machine
        if (sense.die_shut)
        begin
            nxt_q.chg = CH_SHUTDOWN;
        end
        else
        begin
            unique case (q_ff.chg)
                CH_OFF:
                begin
                    if (sense.start_ok && !temp_fault)
                    begin
                        nxt_q.chg = q_ff.fast_req ? CH_FAST : CH_TRICKLE;
                        nxt_q.timer = 16'h0000;
                        nxt_q.checked = 1'b0;
                    end
                end
                CH_TRICKLE, CH_FAST:
                begin
                    if (!sense.start_ok)
                    begin
                        nxt_q.chg = CH_OFF;
                    end
                    else if (temp_fault)
                    begin
                        nxt_q.chg = CH_SUSPEND;
                    end
                    else if ((q_ff.chg == CH_FAST) && sense.batt_low)
                    begin
                        nxt_q.chg = CH_TRICKLE;
                        nxt_q.timer = 16'h0000;
                        nxt_q.checked = 1'b0;
                    end
                    else if ((q_ff.chg == CH_TRICKLE) && !q_ff.checked
                        && (q_ff.timer >= check_at))
                    begin
                        nxt_q.checked = 1'b1;
                        if (sense.batt_low)
                        begin
                            nxt_q.chg = CH_FAIL;
                        end
                    end
                end
                CH_SUSPEND:
                begin
                    if (!temp_fault)
                    begin
                        nxt_q.chg = CH_TRICKLE;
                    end
                end
                CH_FAIL:
                begin
                    if (!sense.batt_low || sense.power_reapply || sense.usb_suspend)
                    begin
                        nxt_q.chg = CH_OFF;
                    end
                end
                CH_SHUTDOWN:
                begin
                    if (sense.power_reapply)
                    begin
                        nxt_q.chg = CH_OFF;
                    end
                end
                default:
                begin
                    nxt_q.chg = CH_OFF;
                end
            endcase
        end
        // Current enable and readable status
        nxt_q.charge_en = ((nxt_q.chg == CH_TRICKLE) || (nxt_q.chg == CH_FAST))
            && !(nxt_q.chg == CH_FAST ? sense.die_warn : sense.die_warn && q_ff.warn_pause_en);
        nxt_q.charge_fast = nxt_q.charge_en && (nxt_q.chg == CH_FAST);
        if (!nxt_q.charge_en)
        begin
            nxt_q.sts = STS_OFF;
        end
        else
        begin
            nxt_q.sts = nxt_q.charge_fast ? STS_FAST : STS_TRICKLE;
        end
        // Indicator blink: toggle each half second fast, every second slow
        if (!nxt_q.charge_en)
        begin
            nxt_q.blink = 1'b0;
            nxt_q.slow_div = SLOW_DIV_RST;
        end
        else if (tick)
        begin
            nxt_q.slow_div = ~q_ff.slow_div;
            if (nxt_q.charge_fast || q_ff.slow_div)
            begin
                nxt_q.blink = ~q_ff.blink;
            end
        end
        nxt_q.ind_oe = nxt_q.charge_en && nxt_q.blink;
        nxt_q.irq = |(flag_word & ~q_ff.mask);
        // Register writes
        if (bus.wr)
        begin
            unique case (bus.addr)
                CTL1_OFS:
                begin
                    if (key_unlocked && !rom_cfg)
                    begin
                        nxt_q.ntc_en = bus.wdata[NTC_EN_BIT];
                        nxt_q.hot_en = bus.wdata[HOT_EN_BIT];
                        nxt_q.cold_en = bus.wdata[COLD_EN_BIT];
                    end
                end
                CTL2_OFS:
                begin
                    if (key_unlocked)
                    begin
                        nxt_q.time_code = bus.wdata[TIME_LSB +: 4];
                    end
                end
                MASK_OFS: nxt_q.mask = bus.wdata;
                MODE_OFS:
                begin
                    nxt_q.fast_req = bus.wdata[FAST_REQ_BIT];
                    nxt_q.warn_pause_en = bus.wdata[WARN_PAUSE_BIT];
                end
                default:
                begin
                end
            endcase
        end
        // Register reads, data valid for one cycle
        if (bus.rd)
        begin
            unique case (bus.addr)
                CTL1_OFS:
                begin
                    nxt_q.rdata[NTC_EN_BIT] = q_ff.ntc_en;
                    nxt_q.rdata[HOT_EN_BIT] = q_ff.hot_en;
                    nxt_q.rdata[COLD_EN_BIT] = q_ff.cold_en;
                end
                CTL2_OFS:
                begin
                    nxt_q.rdata[STS_LSB +: 2] = q_ff.sts;
                    nxt_q.rdata[TIME_LSB +: 4] = q_ff.time_code;
                end
                FLAG_OFS: nxt_q.rdata = flag_word;
                MASK_OFS: nxt_q.rdata = q_ff.mask;
                MODE_OFS:
                begin
                    nxt_q.rdata[FAST_REQ_BIT] = q_ff.fast_req;
                    nxt_q.rdata[WARN_PAUSE_BIT] = q_ff.warn_pause_en;
                end
                default:
                begin
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q_ff <= '0;
            q_ff.chg <= CH_OFF;
            q_ff.time_code <= TIME_RST;
            q_ff.ntc_en <= EN_RST;
            q_ff.hot_en <= EN_RST;
            q_ff.cold_en <= EN_RST;
            q_ff.fast_req <= FAST_REQ_RST;
            q_ff.warn_pause_en <= WARN_PAUSE_RST;
            q_ff.mask <= MASK_RST;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // Outputs straight from the state register
    assign rdata_ff = q_ff.rdata;
    assign charge_en_ff = q_ff.charge_en;
    assign charge_fast_ff = q_ff.charge_fast;
    assign irq_ff = q_ff.irq;
    assign ind_o_ff = q_ff.ind_o;
    assign ind_oe_ff = q_ff.ind_oe;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sts_when_off_a: assert property (!charge_en_ff |-> q_ff.sts == STS_OFF)
        else $error("status not off without current");
    led_dark_a: assert property (!charge_en_ff |-> !ind_oe_ff)
        else $error("indicator lit without current");
    od_low_a: assert property (ind_o_ff == 1'b0)
        else $error("indicator driven high");
    cold_flag_a: assert property ($rose(conds[0]) |=> flags[0])
        else $error("cold flag missed");
    hot_flag_a: assert property ($rose(conds[1]) |=> flags[1])
        else $error("hot flag missed");
    temp_suspend_a: assert property (temp_fault && charging && sense.start_ok
        && !sense.die_shut |=> q_ff.chg == CH_SUSPEND && !charge_en_ff)
        else $error("no suspend on temperature fault");
    resume_a: assert property (q_ff.chg == CH_SUSPEND && !temp_fault
        && !sense.die_shut |=> q_ff.chg == CH_TRICKLE)
        else $error("no trickle resume");
    en_locked_a: assert property (bus.wr && bus.addr == CTL1_OFS
        && (!key_unlocked || rom_cfg) |=> $stable({q_ff.ntc_en, q_ff.hot_en, q_ff.cold_en}))
        else $error("locked enable changed");
    // A read may clear the flag while the level stays high, so only a fresh edge needs it
    shutdown_a: assert property (sense.die_shut |=> !charge_en_ff
        && (flags[4] || $past(sense.die_shut, 2)))
        else $error("shutdown did not stop charging");
    fast_fallback_a: assert property (q_ff.chg == CH_FAST && sense.batt_low
        && sense.start_ok && !temp_fault && !sense.die_shut |=> q_ff.chg == CH_TRICKLE)
        else $error("no fallback to trickle");
    fail_stop_a: assert property (q_ff.chg == CH_FAIL |-> !charge_en_ff)
        else $error("charging during failure");

    fast_blink_c: cover property (charge_fast_ff && $rose(ind_oe_ff));
    suspend_c: cover property (q_ff.chg == CH_SUSPEND ##1 q_ff.chg == CH_TRICKLE);
    fail_c: cover property (q_ff.chg == CH_FAIL ##1 q_ff.chg == CH_OFF);
endmodule

// *** test/csfm_sense_model.sv ***
// Model of the analogue charger side: comparators and power events
`timescale 1ns/1ps
module csfm_sense_model
#(
    parameter int DEFECT_MV = 2850
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Conditions requested by the bench: shut, warn, missing, hot, cold
    input wire logic [4:0] temp_req,
    input wire logic [11:0] batt_mv,
    // Start allowed, power reapplied, USB suspend
    input wire logic [2:0] pwr_req,
    // Comparator levels towards the monitor
    output csfm_pkg::csfm_sense_t sense
);
    import csfm_pkg::*;

    // Comparators settle one clock after the analogue condition changes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sense <= '0;
        end
        else
        begin
            sense.cold <= temp_req[0];
            sense.hot <= temp_req[1];
            sense.ntc_missing <= temp_req[2];
            sense.die_warn <= temp_req[3];
            sense.die_shut <= temp_req[4];
            sense.batt_low <= (batt_mv < 12'(DEFECT_MV));
            sense.start_ok <= pwr_req[2];
            sense.power_reapply <= pwr_req[1];
            sense.usb_suspend <= pwr_req[0];
        end
    end
endmodule

// *** test/tb.sv ***
// Self-checking bench of the charger status and fault monitor
`timescale 1ns/1ps
module tb;
    import csfm_pkg::*;
    logic clk, rst, key_unlocked, rom_cfg, rd_d;
    csfm_bus_t bus;
    csfm_sense_t sense;
    logic [15:0] rdata_ff, seed, exp_w, msk_w;
    logic charge_en_ff, charge_fast_ff, irq_ff, ind_o_ff, ind_oe_ff;
    logic [4:0] temp_req;
    logic [11:0] batt_mv;
    logic [2:0] pwr_req;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    int mismatches, total_checks, cycles;

    csfm_monitor #(.HALF_SEC(4)) uut (.clk(clk), .rst(rst), .bus(bus), .rdata_ff(rdata_ff),
        .key_unlocked(key_unlocked), .rom_cfg(rom_cfg), .sense(sense),
        .charge_en_ff(charge_en_ff), .charge_fast_ff(charge_fast_ff), .irq_ff(irq_ff),
        .ind_o_ff(ind_o_ff), .ind_oe_ff(ind_oe_ff));
    csfm_sense_model model (.clk(clk), .rst(rst), .temp_req(temp_req), .batt_mv(batt_mv),
        .pwr_req(pwr_req), .sense(sense));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wrap_up;
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // Read strobe plus a note of the expected word and the bits that matter
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic setc(input logic [4:0] t);
        @(posedge clk);
        temp_req <= t;
    endtask

    task automatic pulse(input logic [2:0] p);
        @(posedge clk);
        pwr_req <= p;
        @(posedge clk);
        pwr_req <= 3'h4;
    endtask

    // Bounded wait for the charge current to reach a level
    task automatic wait_en(input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (charge_en_ff !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk("charge enable", 16'(v), 16'(charge_en_ff));
    endtask

    // Count indicator toggles over 96 cycles; pin data must stay low
    task automatic blink(input int lo, input int hi);
        int t;
        logic p;
        t = 0;
        @(negedge clk);
        p = ind_oe_ff;
        repeat (96)
        begin
            @(negedge clk);
            if (ind_oe_ff !== p)
                t++;
            p = ind_oe_ff;
            chk("indicator data", 16'h0000, 16'(ind_o_ff));
        end
        chk("blink toggles in range", 16'h0001, 16'(t >= lo && t <= hi));
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Read result watcher: compares against the oldest note
    always @(posedge clk) rd_d <= bus.rd;
    always @(negedge clk)
    begin
        if (rd_d)
        begin
            exp_w = exp_q.pop_front();
            msk_w = msk_q.pop_front();
            chk("read data", exp_w & msk_w, rdata_ff & msk_w);
        end
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 60000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        bus = '0;
        key_unlocked = 1'b0;
        rom_cfg = 1'b0;
        temp_req = 5'h00;
        batt_mv = 12'hE74;
        pwr_req = 3'h0;
        seed = 16'h0020;
        rd_d = 1'b0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(8'hA8, 16'h000E, 16'h000E);
        rd(8'hA9, 16'h0B00, 16'h3F00);
        rd(8'hAB, 16'h0000, 16'hFFFF);
        rd(8'hAC, 16'h0002, 16'h0003);
        seed = lfsr(seed);
        wr({4'h1, seed[3:0]}, seed);
        rd({4'h1, seed[3:0]}, 16'h0000, 16'hFFFF);
        wr(8'hA8, 16'h0000);
        rd(8'hA8, 16'h000E, 16'h000E);
        key_unlocked <= 1'b1;
        rom_cfg <= 1'b1;
        wr(8'hA8, 16'h0000);
        rd(8'hA8, 16'h000E, 16'h000E);
        rom_cfg <= 1'b0;
        wr(8'hA8, 16'h0000);
        rd(8'hA8, 16'h0000, 16'h000E);
        wr(8'hA8, 16'h0002);
        pwr_req <= 3'h4;
        wait_en(1'b1, 8);
        chk("fast current", 16'h0000, 16'(charge_fast_ff));
        rd(8'hA9, 16'h1000, 16'h3000);
        blink(11, 13);
        setc(5'h06);
        cyc(6);
        chk("charge enable", 16'h0001, 16'(charge_en_ff));
        setc(5'h00);
        wr(8'hA8, 16'h000E);
        rd(8'hAA, 16'h0000, 16'hFFFF);
        setc(5'h04);
        wait_en(1'b0, 4);
        setc(5'h00);
        wait_en(1'b1, 6);
        setc(5'h02);
        wait_en(1'b0, 4);
        rd(8'hA9, 16'h0000, 16'h3000);
        cyc(2);
        chk("interrupt", 16'h0001, 16'(irq_ff));
        rd(8'hAA, 16'h8000, 16'h8000);
        rd(8'hAA, 16'h0000, 16'h8000);
        cyc(2);
        chk("interrupt", 16'h0000, 16'(irq_ff));
        setc(5'h00);
        wait_en(1'b1, 6);
        rd(8'hA9, 16'h1000, 16'h3000);
        wr(8'hAB, 16'h4000);
        setc(5'h01);
        wait_en(1'b0, 4);
        cyc(3);
        chk("interrupt", 16'h0000, 16'(irq_ff));
        rd(8'hAA, 16'h4000, 16'h4000);
        setc(5'h00);
        wait_en(1'b1, 6);
        wr(8'hAB, 16'h0000);
        setc(5'h08);
        wait_en(1'b0, 4);
        rd(8'hAA, 16'h0010, 16'h0010);
        setc(5'h00);
        wait_en(1'b1, 6);
        setc(5'h10);
        wait_en(1'b0, 4);
        rd(8'hAA, 16'h0020, 16'h0020);
        setc(5'h00);
        cyc(10);
        chk("charge enable", 16'h0000, 16'(charge_en_ff));
        pulse(3'h6);
        wait_en(1'b1, 8);
        wr(8'hAC, 16'h0003);
        pwr_req <= 3'h0;
        wait_en(1'b0, 6);
        pwr_req <= 3'h4;
        wait_en(1'b1, 6);
        chk("fast current", 16'h0001, 16'(charge_fast_ff));
        rd(8'hA9, 16'h2000, 16'h3000);
        blink(23, 25);
        wr(8'hA9, 16'h0300);
        @(posedge clk);
        batt_mv <= 12'h7D0;
        cyc(3);
        chk("fast current", 16'h0000, 16'(charge_fast_ff));
        rd(8'hA9, 16'h1300, 16'h3F00);
        cyc(17940);
        chk("charge enable", 16'h0001, 16'(charge_en_ff));
        wait_en(1'b0, 80);
        rd(8'hAA, 16'h2000, 16'h2000);
        rd(8'hA9, 16'h0000, 16'h3000);
        seed = lfsr(seed);
        @(posedge clk);
        batt_mv <= 12'hBB8 + {3'h0, seed[8:0]};
        wait_en(1'b1, 10);
        wr(8'hAC, 16'h0002);
        wr(8'hA9, 16'h0000);
        @(posedge clk);
        batt_mv <= 12'h7D0;
        cyc(14340);
        chk("charge enable", 16'h0001, 16'(charge_en_ff));
        wait_en(1'b0, 80);
        pulse(3'h5);
        wait_en(1'b1, 8);
        // Trickle with pausing switched off keeps charging on a die warning
        wr(8'hAC, 16'h0000);
        setc(5'h08);
        cyc(6);
        chk("charge enable", 16'h0001, 16'(charge_en_ff));
        setc(5'h00);
        // Reset in mid-run restores the defaults and stops the current
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        chk("charge enable", 16'h0000, 16'(charge_en_ff));
        @(posedge clk);
        rst <= 1'b0;
        rd(8'hA9, 16'h0B00, 16'h0F00);
        rd(8'hAC, 16'h0002, 16'h0003);
        wrap_up();
    end
endmodule
